// ===== hdl/fbas_csum.sv
// Block checksum: complement of the byte-wise sum of a window
`timescale 1ns/1ps
`default_nettype none
module fbas_csum #(
    parameter int N = 32
) (
    // Window bytes, byte 0 in the low lanes
    input  wire logic [8*N-1:0] bytes_i,
    // Expected checksum
    output logic      [7:0]     csum_o
);
    import fbas_pkg::*;
    logic [7:0] sum;

    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < N; i++) begin
            sum = sum + bytes_i[8*i +: 8];
        end
        csum_o = CSUM_FULL - sum;
    end
endmodule
`default_nettype wire

// ===== hdl/fbas_dev.sv
// Device end: block window, checksum commit and key-based modes
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Access select zero enables general block transfer outside locked mode
// - Window 0x40-0x5f shows selected 32 bytes
// - Single window bytes rewritable by offset
// - Commit only after correct block checksum
// - Block select picks 32-byte slice
// - Bytes past 32 in one burst ignored
// - Written values stored without range checks
// - Committed data survives reset
// - Three 32-byte information blocks A, B, C
// - Opened: subclass then block select
// - Block B is subclass 58 offset 32
// - Locked path: select 1-3 loads A-C
// - Info block written back after checksum
// - Locked mode: block A read-only
// - Three modes with access table
// - Keys writable only in privileged mode
// - Key words consecutive; any other completed control word breaks
// - Sealed flag tracks locked mode
// - Privilege key pair clears full-access flag
// - Key is two 16-bit words, key1 first
// - Host sends key one first, byte-swapped
// - Keys differ from subcommand codes
// - Checksum is 255 minus byte sum
module fbas_dev #(
    parameter int GEN_BLOCKS = 8
) (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    // Memory initialise (factory erase), not a reset
    input  wire logic               nv_init_i,
    // Status
    output fbas_pkg::fbas_mode_t    mode_o,
    output logic                    commit_ok_o,
    output logic                    commit_err_o,
    // Link
    fbas_if.dev                     lnk
);
    import fbas_pkg::*;
    localparam int GB = $clog2(GEN_BLOCKS);

    // ------------------------------------------------------------
    // Non-volatile store and window
    // ------------------------------------------------------------
    logic [7:0]  info_mem [INFO_BYTES];
    logic [7:0]  gen_mem  [GEN_BLOCKS*WIN_BYTES];
    logic [31:0] open_key_q;
    logic [31:0] priv_key_q;
    logic [7:0]  win_q [WIN_BYTES];
    logic [8*WIN_BYTES-1:0] win_flat;
    logic [7:0]  csum_exp;

    fbas_mode_t  mode_q;
    fbas_src_t   src_d;
    fbas_src_t   src_q;
    logic [7:0]  sub_q;
    logic [7:0]  blk_q;
    logic [7:0]  acc_q;
    logic [7:0]  csum_q;
    logic [7:0]  ctl_lo_q;
    logic [1:0]  seq_q;
    logic [5:0]  burst_q;
    logic        over_q;
    logic        load_q;
    logic [6:0]  ibase_d;
    logic [6:0]  ibase_q;
    logic [GB-1:0] gblk_d;
    logic [GB-1:0] gblk_q;

    logic        wr;
    logic        info_path;
    logic        win_hit;
    logic        ctl_done;
    logic [15:0] ctl_word;
    logic        a_locked;
    logic        commit_try;
    logic        commit_go;

    assign wr        = lnk.cmd_wr;
    assign ctl_word  = {lnk.cmd_data, ctl_lo_q};
    assign ctl_done  = wr && lnk.cmd_addr == ADR_CTL_HI;
    assign win_hit   = lnk.cmd_addr >= ADR_WIN
                       && lnk.cmd_addr <= ADR_WIN_END;
    // locked or nonzero access select uses info path
    assign info_path = mode_q == MODE_LOCK || acc_q != ACC_GENERAL;
    // block A is read-only when locked
    assign a_locked  = mode_q == MODE_LOCK && src_q == SRC_INFO
                       && ibase_q == 7'd0;

    for (genvar g = 0; g < WIN_BYTES; g++) begin : g_flat
        assign win_flat[8*g +: 8] = win_q[g];
    end

    fbas_csum #(.N(WIN_BYTES)) u_csum (
        .bytes_i (win_flat),
        .csum_o  (csum_exp)
    );

    // ------------------------------------------------------------
    // Source decode for the next load
    // ------------------------------------------------------------
    always_comb begin
        src_d   = SRC_NONE;
        ibase_d = 7'd0;
        gblk_d  = sub_q[GB-1:0] ^ blk_q[GB-1:0];
        if (info_path) begin
            // select 1, 2, 3 load A, B, C
            if (blk_q >= 8'h01 && blk_q <= 8'h03) begin
                src_d   = SRC_INFO;
                ibase_d = 7'(({1'b0, blk_q[1:0]} - 3'd1) * 32);
            end
        end else if (sub_q == INFO_SUBCLASS) begin
            // block index 1 is offsets 32..63
            if (blk_q <= 8'h02) begin
                src_d   = SRC_INFO;
                ibase_d = 7'(blk_q[1:0] * 32);
            end
        end else if (sub_q == KEY_SUBCLASS) begin
            if (blk_q == 8'h00) src_d = SRC_KEY;
        end else begin
            // subclass and block pick a 32-byte slice
            src_d = SRC_GEN;
        end
    end

    // ------------------------------------------------------------
    // Selector registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sub_q  <= 8'h00;
            blk_q  <= 8'h00;
            acc_q  <= 8'h00;
            load_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (wr && lnk.cmd_addr == ADR_SUBCLASS
                && mode_q != MODE_LOCK) begin
                sub_q  <= lnk.cmd_data;
                load_q <= 1'b1;
            end
            if (wr && lnk.cmd_addr == ADR_BLKSEL) begin
                blk_q  <= lnk.cmd_data;
                load_q <= 1'b1;
            end
            if (wr && lnk.cmd_addr == ADR_ACCSEL
                && mode_q != MODE_LOCK)
                acc_q <= lnk.cmd_data;
        end
    end

    // ------------------------------------------------------------
    // Window load, byte edits and burst limit
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            src_q   <= SRC_NONE;
            ibase_q <= 7'd0;
            gblk_q  <= '0;
            burst_q <= 6'd0;
            over_q  <= 1'b0;
            for (int i = 0; i < WIN_BYTES; i++) win_q[i] <= 8'h00;
        end else begin
            if (wr && lnk.cmd_first) burst_q <= 6'd0;
            if (load_q) begin
                // selected block copied to the window
                src_q   <= src_d;
                ibase_q <= ibase_d;
                gblk_q  <= gblk_d;
                over_q  <= 1'b0;
                for (int i = 0; i < WIN_BYTES; i++) begin
                    case (src_d)
                        SRC_INFO: win_q[i] <= info_mem[ibase_d + 7'(i)];
                        SRC_GEN:  win_q[i] <= gen_mem[{gblk_d, 5'(i)}];
                        SRC_KEY:  win_q[i] <= (i >= 4 && i < 8) ?
                            priv_key_q[8*(3-(i%4)) +: 8] : 8'h00;
                        default:  win_q[i] <= 8'h00;
                    endcase
                    if (src_d == SRC_KEY && i < 4)
                        win_q[i] <= open_key_q[8*(3-i) +: 8];
                end
            end else if (wr && win_hit) begin
                // writes past the block size are dropped
                if ((lnk.cmd_first ? 6'd0 : burst_q) >= BURST_MAX)
                    over_q <= 1'b1;
                else begin
                    win_q[lnk.cmd_addr[4:0]] <= lnk.cmd_data;
                    burst_q <= (lnk.cmd_first ? 6'd0 : burst_q) + 6'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checksum commit
    // ------------------------------------------------------------
    assign commit_try = wr && lnk.cmd_addr == ADR_CSUM && !load_q;
    // only a matching sum on an allowed block
    assign commit_go  = commit_try && lnk.cmd_data == csum_exp
                        && !over_q && !a_locked && src_q != SRC_NONE
                        && (src_q != SRC_KEY || mode_q == MODE_PRIV);

    // store has no reset; only the erase input and a commit write it
    always_ff @(posedge ref_clk_i) begin
        if (nv_init_i) begin
            for (int i = 0; i < INFO_BYTES; i++) info_mem[i] <= 8'h00;
            for (int i = 0; i < GEN_BLOCKS*WIN_BYTES; i++)
                gen_mem[i] <= 8'h00;
            open_key_q <= OPEN_KEY_INIT;
            priv_key_q <= PRIV_KEY_INIT;
        end else if (commit_go) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
                if (src_q == SRC_INFO)
                    info_mem[ibase_q + 7'(i)] <= win_q[i];
                if (src_q == SRC_GEN)
                    gen_mem[{gblk_q, 5'(i)}] <= win_q[i];
            end
            // keys as read: key0 high, key1 low
            if (src_q == SRC_KEY) begin
                open_key_q <= {win_q[0], win_q[1], win_q[2], win_q[3]};
                priv_key_q <= {win_q[4], win_q[5], win_q[6], win_q[7]};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            csum_q       <= 8'h00;
            commit_ok_o  <= 1'b0;
            commit_err_o <= 1'b0;
        end else begin
            commit_ok_o  <= commit_go;
            commit_err_o <= commit_try && !commit_go;
            if (commit_try) csum_q <= lnk.cmd_data;
        end
    end

    // ------------------------------------------------------------
    // Key sequence and security mode
    // ------------------------------------------------------------
    // Mode is volatile: a reset returns to the locked level.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_q   <= MODE_RST;
            ctl_lo_q <= 8'h00;
            seq_q    <= 2'd0;
        end else begin
            if (wr && lnk.cmd_addr == ADR_CTL_LO)
                ctl_lo_q <= lnk.cmd_data;
            if (ctl_done) begin
                // any completed word ends a pending pair
                seq_q <= 2'd0;
                // first word is key one byte-swapped
                if (ctl_word == {open_key_q[7:0], open_key_q[15:8]}
                    && mode_q == MODE_LOCK)
                    seq_q <= 2'd1;
                if (ctl_word == {priv_key_q[7:0], priv_key_q[15:8]}
                    && mode_q == MODE_OPEN)
                    seq_q <= 2'd2;
                if (seq_q == 2'd1 && ctl_word ==
                    {open_key_q[23:16], open_key_q[31:24]})
                    mode_q <= MODE_OPEN;
                if (seq_q == 2'd2 && ctl_word ==
                    {priv_key_q[23:16], priv_key_q[31:24]})
                    mode_q <= MODE_PRIV;
                if (ctl_word == SUB_SEAL) begin
                    mode_q <= MODE_LOCK;
                    seq_q  <= 2'd0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read answers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lnk.rsp_valid <= 1'b0;
            lnk.rsp_data  <= 8'h00;
            mode_o        <= MODE_RST;
        end else begin
            mode_o        <= mode_q;
            lnk.rsp_valid <= lnk.cmd_rd;
            lnk.rsp_data  <= 8'h00;
            if (lnk.cmd_rd) begin
                if (lnk.cmd_addr == ADR_CTL_HI) begin
                    lnk.rsp_data[SSB_SEALED-8] <= mode_q == MODE_LOCK;
                    lnk.rsp_data[SSB_FULL-8]   <= mode_q != MODE_PRIV;
                end else if (win_hit)
                    lnk.rsp_data <= win_q[lnk.cmd_addr[4:0]];
                else if (lnk.cmd_addr == ADR_CSUM)
                    lnk.rsp_data <= csum_q;
                else if (lnk.cmd_addr == ADR_BLKSEL)
                    lnk.rsp_data <= blk_q;
                else if (mode_q != MODE_LOCK) begin
                    if (lnk.cmd_addr == ADR_SUBCLASS)
                        lnk.rsp_data <= sub_q;
                    if (lnk.cmd_addr == ADR_ACCSEL)
                        lnk.rsp_data <= acc_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/fbas_host.sv
// Host end: issues command bytes, key pairs and block checksums
`timescale 1ns/1ps
`default_nettype none
module fbas_host (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    // User request
    input  wire logic               req_valid_i,
    input  wire fbas_pkg::fbas_req_t req_kind_i,
    input  wire logic               req_first_i,
    input  wire logic [7:0]         req_addr_i,
    input  wire logic [31:0]        req_data_i,
    output logic                    req_ready_o,
    // Read answer
    output logic                    rd_valid_o,
    output logic [7:0]              rd_data_o,
    // Link
    fbas_if.hst                     lnk
);
    import fbas_pkg::*;
    fbas_hstate_t st_q;
    logic [1:0]   step_q;
    logic [31:0]  key_q;
    logic [7:0]   rd_addr_q;
    logic [7:0]   sh_q [WIN_BYTES];
    logic [8*WIN_BYTES-1:0] sh_flat;
    logic [7:0]   csum;
    logic         take;

    assign take = req_valid_i && req_ready_o;

    for (genvar g = 0; g < WIN_BYTES; g++) begin : g_flat
        assign sh_flat[8*g +: 8] = sh_q[g];
    end

    fbas_csum #(.N(WIN_BYTES)) u_csum (
        .bytes_i (sh_flat),
        .csum_o  (csum)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q        <= H_IDLE;
            step_q      <= 2'd0;
            key_q       <= 32'h0000_0000;
            req_ready_o <= 1'b0;
        end else begin
            case (st_q)
                H_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (take && req_kind_i == REQ_KEY) begin
                        st_q        <= H_KEY;
                        step_q      <= 2'd0;
                        key_q       <= req_data_i;
                        req_ready_o <= 1'b0;
                    end
                end
                H_KEY: begin
                    step_q <= step_q + 2'd1;
                    if (step_q == 2'd3) begin
                        st_q        <= H_IDLE;
                        req_ready_o <= 1'b1;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lnk.cmd_wr    <= 1'b0;
            lnk.cmd_rd    <= 1'b0;
            lnk.cmd_first <= 1'b0;
            lnk.cmd_addr  <= 8'h00;
            lnk.cmd_data  <= 8'h00;
        end else begin
            lnk.cmd_wr    <= 1'b0;
            lnk.cmd_rd    <= 1'b0;
            lnk.cmd_first <= 1'b0;
            if (st_q == H_KEY) begin
                lnk.cmd_wr    <= 1'b1;
                lnk.cmd_first <= 1'b1;
                lnk.cmd_addr  <= step_q[0] ? ADR_CTL_HI : ADR_CTL_LO;
                // Low byte of each word goes to 0x00, so it takes
                // the upper byte of the half as read
                case (step_q)
                    2'd0:    lnk.cmd_data <= key_q[15:8];
                    2'd1:    lnk.cmd_data <= key_q[7:0];
                    2'd2:    lnk.cmd_data <= key_q[31:24];
                    default: lnk.cmd_data <= key_q[23:16];
                endcase
            end else if (take) begin
                lnk.cmd_first <= req_first_i;
                lnk.cmd_addr  <= req_addr_i;
                lnk.cmd_data  <= req_data_i[7:0];
                case (req_kind_i)
                    REQ_RD:  lnk.cmd_rd <= 1'b1;
                    REQ_WR:  lnk.cmd_wr <= 1'b1;
                    REQ_COMMIT: begin
                        lnk.cmd_wr    <= 1'b1;
                        lnk.cmd_first <= 1'b1;
                        lnk.cmd_addr  <= ADR_CSUM;
                        lnk.cmd_data  <= csum;
                    end
                    default: lnk.cmd_wr <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Shadow of the window and read answers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 8'h00;
            rd_addr_q  <= 8'h00;
            for (int i = 0; i < WIN_BYTES; i++) sh_q[i] <= 8'h00;
        end else begin
            rd_valid_o <= lnk.rsp_valid;
            if (lnk.rsp_valid) rd_data_o <= lnk.rsp_data;
            if (lnk.cmd_rd) rd_addr_q <= lnk.cmd_addr;
            if (lnk.rsp_valid && rd_addr_q >= ADR_WIN
                && rd_addr_q <= ADR_WIN_END)
                sh_q[rd_addr_q[4:0]] <= lnk.rsp_data;
            if (lnk.cmd_wr && lnk.cmd_addr >= ADR_WIN
                && lnk.cmd_addr <= ADR_WIN_END)
                sh_q[lnk.cmd_addr[4:0]] <= lnk.cmd_data;
        end
    end
endmodule
`default_nettype wire

// ===== pkg/fbas_if.sv
// Byte command link between host and device
`timescale 1ns/1ps
`default_nettype none
interface fbas_if (
    input wire logic ref_clk_i
);
    logic       cmd_wr;
    logic       cmd_rd;
    logic       cmd_first;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       rsp_valid;
    logic [7:0] rsp_data;

    modport dev (
        input  cmd_wr, cmd_rd, cmd_first, cmd_addr, cmd_data,
        output rsp_valid, rsp_data
    );
    modport hst (
        output cmd_wr, cmd_rd, cmd_first, cmd_addr, cmd_data,
        input  rsp_valid, rsp_data
    );
endinterface
`default_nettype wire

// ===== pkg/fbas_pkg.sv
// Shared constants and types for the flash block access block
package fbas_pkg;
    // ------------------------------------------------------------
    // Command space map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADR_CTL_LO    = 8'h00;
    localparam logic [7:0]  ADR_CTL_HI    = 8'h01;
    localparam logic [7:0]  ADR_SUBCLASS  = 8'h3e;
    localparam logic [7:0]  ADR_BLKSEL    = 8'h3f;
    localparam logic [7:0]  ADR_WIN       = 8'h40;
    localparam logic [7:0]  ADR_WIN_END   = 8'h5f;
    localparam logic [7:0]  ADR_CSUM      = 8'h60;
    localparam logic [7:0]  ADR_ACCSEL    = 8'h61;
    // ------------------------------------------------------------
    // Sizes and selector values
    // ------------------------------------------------------------
    localparam int          WIN_BYTES     = 32;
    localparam int          INFO_BYTES    = 96;
    localparam int          KEY_BYTES     = 8;
    localparam logic [7:0]  ACC_GENERAL   = 8'h00;
    localparam logic [7:0]  INFO_SUBCLASS = 8'd58;
    localparam logic [7:0]  KEY_SUBCLASS  = 8'd112;
    localparam logic [7:0]  CSUM_FULL     = 8'hff;
    localparam logic [5:0]  BURST_MAX     = 6'd32;
    // ------------------------------------------------------------
    // Control words and status bits
    // ------------------------------------------------------------
    localparam logic [15:0] SUB_SEAL      = 16'h0020;
    localparam int          SSB_SEALED    = 13;
    localparam int          SSB_FULL      = 14;
    // Arbitrary default keys, loaded only by a memory initialise
    localparam logic [31:0] OPEN_KEY_INIT = 32'h3c5a_a5c3;
    localparam logic [31:0] PRIV_KEY_INIT = 32'hffff_ffff;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PRIV = 2'b00,
        MODE_OPEN = 2'b01,
        MODE_LOCK = 2'b10
    } fbas_mode_t;
    localparam fbas_mode_t MODE_RST = MODE_LOCK;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_GEN  = 2'b01,
        SRC_INFO = 2'b10,
        SRC_KEY  = 2'b11
    } fbas_src_t;
    typedef enum logic [1:0] {
        REQ_RD     = 2'b00,
        REQ_WR     = 2'b01,
        REQ_KEY    = 2'b10,
        REQ_COMMIT = 2'b11
    } fbas_req_t;
    typedef enum logic [0:0] {
        H_IDLE = 1'b0,
        H_KEY  = 1'b1
    } fbas_hstate_t;
endpackage

// ===== tb/fbas_props.sv
// Link protocol checks between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module fbas_props
    import fbas_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // Link signals
    input wire logic       cmd_wr,
    input wire logic       cmd_rd,
    input wire logic       cmd_first,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_rsp_after_read: assert property (cmd_rd |=> rsp_valid)
        else $error("read got no answer");
    a_rsp_needs_read: assert property (rsp_valid |-> $past(cmd_rd))
        else $error("answer without a read");
    a_rsp_idle_zero: assert property (!rsp_valid |-> rsp_data == 8'h00)
        else $error("answer data not zero when idle");
    a_one_op: assert property (!(cmd_wr && cmd_rd))
        else $error("read and write in one cycle");
    a_key_word_pair: assert property (
        cmd_wr && cmd_addr == ADR_CTL_LO |=> cmd_wr && cmd_addr == ADR_CTL_HI)
        else $error("control word not completed next cycle");
    a_first_is_write: assert property (cmd_first |-> cmd_wr)
        else $error("burst start without write");
    a_unmapped_zero: assert property (
        cmd_rd && cmd_addr > ADR_ACCSEL |=> rsp_data == 8'h00)
        else $error("unmapped read not zero");
    a_quiet_release: assert property (
        $fell(rst_i) |-> !cmd_wr && !cmd_rd)
        else $error("link active at reset release");
    c_read: cover property (cmd_rd ##1 rsp_valid);
    c_key: cover property (cmd_wr && cmd_addr == ADR_CTL_HI);
    c_csum: cover property (cmd_wr && cmd_addr == ADR_CSUM && cmd_data != 0);
endmodule
`default_nettype wire

// ===== tb/flash_block_access_security_bench.sv
// Bench joining host and device ends over the command link
`timescale 1ns/1ps
`default_nettype none
module flash_block_access_security_bench;
    import fbas_pkg::*;
    logic            ref_clk_i = 1'b0;
    logic            rst_i     = 1'b1;
    logic            nv_init   = 1'b1;
    logic            rv        = 1'b0;
    fbas_req_t       rk        = REQ_RD;
    logic            rf        = 1'b0;
    logic [7:0]      ra        = 8'h00;
    logic [31:0]     rdat      = 32'h0;
    logic [7:0]      csum;
    wire logic       ready;
    wire logic       rd_valid;
    wire logic       ok;
    wire logic       err;
    wire logic [7:0] rd_data;
    fbas_mode_t      mode;
    int miscompares = 0, samples_checked = 0, oks = 0, errs = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (ok === 1'b1) oks++;
        if (err === 1'b1) errs++;
    end
    fbas_if lnk (.ref_clk_i(ref_clk_i));
    fbas_host u_fbas_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .req_valid_i(rv), .req_kind_i(rk), .req_first_i(rf), .req_addr_i(ra),
        .req_data_i(rdat), .req_ready_o(ready), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .lnk(lnk));
    fbas_dev u_fbas_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .nv_init_i(nv_init), .mode_o(mode), .commit_ok_o(ok),
        .commit_err_o(err), .lnk(lnk));
    fbas_props u_fbas_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .cmd_wr(lnk.cmd_wr), .cmd_rd(lnk.cmd_rd), .cmd_first(lnk.cmd_first),
        .cmd_addr(lnk.cmd_addr), .cmd_data(lnk.cmd_data),
        .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));
    task automatic cmp8(input string what, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmpm(input fbas_mode_t e);
        cmp8("mode", {6'h00, e}, {6'h00, mode});
    endtask
    // Called at a falling edge; request held until the edge that takes it
    task automatic req(input fbas_req_t k, input logic [7:0] a,
                       input logic [31:0] d, input logic f = 1'b0);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 100) miscompares++;
        rv = 1'b1;
        rk = k;
        ra = a;
        rdat = d;
        rf = f;
        @(negedge ref_clk_i);
        rv = 1'b0;
        // One idle edge: no strobe re-raised in the same step, and a
        // select write finishes its window load before the next byte
        @(negedge ref_clk_i);
    endtask
    task automatic chk(input string what, input logic [7:0] a, m, e);
        int n;
        req(REQ_RD, a, 32'h0);
        n = 0;
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 20) miscompares++;
        cmp8(what, e, rd_data & m);
    endtask
    task automatic t_sealed();
        cmpm(MODE_LOCK);
        chk("status", ADR_CTL_HI, 8'h60, 8'h60);
        req(REQ_WR, ADR_SUBCLASS, {24'h0, INFO_SUBCLASS});
    endtask
    task automatic t_unlock();
        req(REQ_KEY, 8'h00, OPEN_KEY_INIT);
        chk("status", ADR_CTL_HI, 8'h20, 8'h00);
        cmpm(MODE_OPEN);
        chk("subclass", ADR_SUBCLASS, 8'hff, 8'h00);
        req(REQ_WR, ADR_SUBCLASS, {24'h0, KEY_SUBCLASS});
        chk("key", ADR_WIN, 8'hff, OPEN_KEY_INIT[31:24]);
        chk("key", ADR_WIN + 8'h04, 8'hff, PRIV_KEY_INIT[31:24]);
        req(REQ_KEY, 8'h00, PRIV_KEY_INIT);
        chk("status", ADR_CTL_HI, 8'h40, 8'h00);
        cmpm(MODE_PRIV);
    endtask
    task automatic t_general();
        req(REQ_WR, ADR_ACCSEL, {24'h0, ACC_GENERAL});
        req(REQ_WR, ADR_SUBCLASS, {24'h0, INFO_SUBCLASS});
        req(REQ_WR, ADR_BLKSEL, 32'h1);
        csum = CSUM_FULL;
        for (int i = 0; i < WIN_BYTES; i++) begin
            req(REQ_WR, ADR_WIN + 8'(i), {24'h0, 8'(i * 37)}, i == 0);
            csum -= 8'(i * 37);
        end
        req(REQ_WR, ADR_CSUM, {24'h0, csum ^ 8'h01});
        chk("window", ADR_WIN + 8'h0a, 8'hff, 8'(370));
        cmp8("errors", 8'h01, 8'(errs));
        req(REQ_COMMIT, 8'h00, 32'h0);
        chk("window", ADR_WIN + 8'h1f, 8'hff, 8'(31 * 37));
        cmp8("commits", 8'h01, 8'(oks));
    endtask
    task automatic t_persist();
        rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        req(REQ_WR, ADR_BLKSEL, 32'h2);
        chk("window", ADR_WIN + 8'h0a, 8'hff, 8'(370));
        req(REQ_WR, ADR_BLKSEL, 32'h1);
        req(REQ_WR, ADR_WIN, 32'h55, 1'b1);
        // Shadow byte 10 still holds block B; match it so that only
        // the read-only rule can refuse the commit
        req(REQ_WR, ADR_WIN + 8'h0a, 32'h0);
        req(REQ_COMMIT, 8'h00, 32'h0);
        chk("unmapped", 8'h70, 8'hff, 8'h00);
        cmp8("errors", 8'h02, 8'(errs));
        req(REQ_WR, ADR_BLKSEL, 32'h1);
        chk("block A", ADR_WIN, 8'hff, 8'h00);
    endtask
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge ref_clk_i);
        rst_i = 1'b0;
        nv_init = 1'b0;
        t_sealed();
        t_unlock();
        t_general();
        t_persist();
        conclude();
    end
endmodule
`default_nettype wire
